// file: hw/rrt_pkg.sv
// Package of constants for the ROM/RAM/I-O/timer device and its bus host.
package rrt_pkg;
    // ****************************************************************
    // Device address decode
    // ****************************************************************
    localparam logic [2:0] RRT_ADDR_PA_DATA = 3'h0;
    localparam logic [2:0] RRT_ADDR_PA_DIR = 3'h1;
    localparam logic [2:0] RRT_ADDR_PB_DATA = 3'h2;
    localparam logic [2:0] RRT_ADDR_PB_DIR = 3'h3;
    localparam int RRT_ADDR_TIMER_BIT = 2;
    localparam int RRT_ADDR_IRQEN_BIT = 3;
    localparam int RRT_ADDR_FLAGSEL_BIT = 0;
    localparam int RRT_FLAG_BIT = 7;
    localparam logic [7:0] RRT_REG_RESET = 8'h00;
    localparam logic [10:0] RRT_DIV1 = 11'h000;
    localparam logic [10:0] RRT_DIV8 = 11'h007;
    localparam logic [10:0] RRT_DIV64 = 11'h03f;
    localparam logic [10:0] RRT_DIV1024 = 11'h3ff;
    // ****************************************************************
    // Host APB register map
    // ****************************************************************
    localparam logic [4:0] RRT_HOST_CMD = 5'h00;
    localparam logic [4:0] RRT_HOST_WDATA = 5'h04;
    localparam logic [4:0] RRT_HOST_RDATA = 5'h08;
    localparam logic [4:0] RRT_HOST_STATUS = 5'h0c;
    localparam logic [4:0] RRT_HOST_MASK = 5'h10;
    localparam int RRT_CMD_RW_BIT = 16;
    localparam int RRT_CMD_SEL_LSB = 12;
    localparam int RRT_ST_DONE_BIT = 0;
    localparam int RRT_ST_IRQ_BIT = 1;
    typedef enum logic [1:0] {RRT_SEL_ROM, RRT_SEL_RAM, RRT_SEL_IOT} rrt_sel_t;
endpackage : rrt_pkg

// file: hw/rrt_bus_if.sv
// Interface joining the device and the bus host.
`timescale 1ns/1ps
`default_nettype none
interface rrt_bus_if;
    logic rom_sel;
    logic ram_sel;
    logic iot_sel;
    logic rw;
    logic [9:0] addr;
    logic [7:0] host_d;
    logic host_d_oe_n;
    logic [7:0] dev_d;
    logic dev_d_oe_n;
    logic timer_irq_n;
    modport device(input rom_sel, ram_sel, iot_sel, rw, addr, host_d, host_d_oe_n,
        output dev_d, dev_d_oe_n, timer_irq_n);
    modport host(output rom_sel, ram_sel, iot_sel, rw, addr, host_d, host_d_oe_n,
        input dev_d, dev_d_oe_n, timer_irq_n);
endinterface : rrt_bus_if
`default_nettype wire

// file: hw/rrt_device.sv
// Device end: ROM, RAM, two ports and interval timer behind the select decode.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rrt_device
    import rrt_pkg::*;
#(
    parameter int RAM_WORDS = 64,
    parameter int ROM_WORDS = 1024
) (
    input wire logic pclk,
    input wire logic presetn,
    rrt_bus_if.device bus,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_n,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_n,
    input wire logic [7:0] rom_data
);
    logic [7:0] ram_mem [RAM_WORDS];
    logic [7:0] pa_data_reg;
    logic [7:0] port_a_direction_reg;
    logic [7:0] pb_data_reg;
    logic [7:0] port_b_direction_reg;
    logic [7:0] count_reg;
    logic [10:0] pre_reg;
    logic [10:0] div_reg;
    logic flag_reg;
    logic irq_en_reg;
    logic [7:0] rd_reg;
    logic oe_n_reg;
    logic rom_rd;
    logic ram_wr;
    logic ram_rd;
    logic iot_wr;
    logic iot_rd;
    logic timer_wr;
    logic timer_rd;
    logic timer_acc;
    logic tick;
    logic expire;
    logic [7:0] pa_view;
    logic [7:0] pb_view;
    logic [$clog2(RAM_WORDS)-1:0] ram_index;

    // ****************************************************************
    // Decode
    // ****************************************************************
    // A select counts only while the other two are low, so a fault that raises
    // two selects at once reaches no target.
    function automatic logic sel_only(input logic mine, input logic other_a,
        input logic other_b);
        sel_only = mine && !other_a && !other_b;
    endfunction : sel_only

    assign rom_rd = sel_only(bus.rom_sel, bus.ram_sel, bus.iot_sel) && bus.rw;
    assign ram_wr = sel_only(bus.ram_sel, bus.rom_sel, bus.iot_sel) && !bus.rw;
    assign ram_rd = sel_only(bus.ram_sel, bus.rom_sel, bus.iot_sel) && bus.rw;
    assign iot_wr = sel_only(bus.iot_sel, bus.rom_sel, bus.ram_sel) && !bus.rw;
    assign iot_rd = sel_only(bus.iot_sel, bus.rom_sel, bus.ram_sel) && bus.rw;
    assign timer_wr = iot_wr && bus.addr[RRT_ADDR_TIMER_BIT];
    assign timer_rd = iot_rd && bus.addr[RRT_ADDR_TIMER_BIT];
    assign timer_acc = timer_wr || timer_rd;
    assign ram_index = bus.addr[$clog2(RAM_WORDS)-1:0];
    // A port read shows the pin for inputs and the register for outputs;
    // the register itself only changes on a write.
    assign pa_view = (pa_in & ~port_a_direction_reg) | (pa_data_reg & port_a_direction_reg);
    assign pb_view = (pb_in & ~port_b_direction_reg) | (pb_data_reg & port_b_direction_reg);

    function automatic logic [10:0] div_of(input logic [1:0] code);
        unique case (code)
            2'b00: div_of = RRT_DIV1;
            2'b01: div_of = RRT_DIV8;
            2'b10: div_of = RRT_DIV64;
            2'b11: div_of = RRT_DIV1024;
        endcase
    endfunction : div_of

    // ****************************************************************
    // Memory and port registers
    // ****************************************************************
    // The RAM has no reset; its words are unknown until first written.
    always_ff @(posedge pclk) begin
        if (ram_wr) begin
            ram_mem[ram_index] <= bus.host_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_data_reg <= RRT_REG_RESET;
            port_a_direction_reg <= RRT_REG_RESET;
            pb_data_reg <= RRT_REG_RESET;
            port_b_direction_reg <= RRT_REG_RESET;
        end else if (iot_wr && !bus.addr[RRT_ADDR_TIMER_BIT]) begin
            // A3 plays no part in the port decode.
            unique case (bus.addr[2:0])
                RRT_ADDR_PA_DATA: pa_data_reg <= bus.host_d;
                RRT_ADDR_PA_DIR: port_a_direction_reg <= bus.host_d;
                RRT_ADDR_PB_DATA: pb_data_reg <= bus.host_d;
                RRT_ADDR_PB_DIR: port_b_direction_reg <= bus.host_d;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Interval timer
    // ****************************************************************
    // The prescaler counts down from the chosen interval minus one, so one count
    // lasts exactly that many clocks.
    assign tick = (pre_reg == 11'h000);
    assign expire = tick && (count_reg == 8'h00) && !flag_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= RRT_REG_RESET;
            pre_reg <= RRT_DIV1;
            div_reg <= RRT_DIV1;
        end else if (timer_wr) begin
            count_reg <= bus.host_d;
            div_reg <= div_of(bus.addr[1:0]);
            pre_reg <= div_of(bus.addr[1:0]);
        end else if (flag_reg) begin
            count_reg <= count_reg - 8'h01;
            pre_reg <= RRT_DIV1;
        end else if (tick) begin
            count_reg <= count_reg - 8'h01;
            pre_reg <= div_reg;
        end else begin
            pre_reg <= pre_reg - 11'h001;
        end
    end

    // After expiry the count keeps falling at the full clock rate.
    // Expiry wins over a clear, so a read that meets the expiry keeps the flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else if (expire) begin
            flag_reg <= 1'b1;
        end else if (timer_acc) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= 1'b0;
        end else if (timer_acc) begin
            irq_en_reg <= bus.addr[RRT_ADDR_IRQEN_BIT];
        end
    end

    // ****************************************************************
    // Read data and pins
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_reg <= RRT_REG_RESET;
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= 1'b1;
            // Read data is registered and stands for the one cycle after the select.
            // The ROM lies outside, so rom_data must follow the address in the same cycle.
            if (rom_rd) begin
                rd_reg <= rom_data;
                oe_n_reg <= 1'b0;
            end else if (ram_rd) begin
                rd_reg <= ram_mem[ram_index];
                oe_n_reg <= 1'b0;
            end else if (iot_rd) begin
                oe_n_reg <= 1'b0;
                if (bus.addr[RRT_ADDR_TIMER_BIT]) begin
                    if (bus.addr[RRT_ADDR_FLAGSEL_BIT]) begin
                        rd_reg <= {flag_reg, 7'h00};
                    end else begin
                        rd_reg <= count_reg;
                    end
                end else begin
                    unique case (bus.addr[2:0])
                        RRT_ADDR_PA_DATA: rd_reg <= pa_view;
                        RRT_ADDR_PA_DIR: rd_reg <= port_a_direction_reg;
                        RRT_ADDR_PB_DATA: rd_reg <= pb_view;
                        RRT_ADDR_PB_DIR: rd_reg <= port_b_direction_reg;
                        default: rd_reg <= RRT_REG_RESET;
                    endcase
                end
            end
        end
    end

    assign bus.dev_d = rd_reg;
    assign bus.dev_d_oe_n = oe_n_reg;
    // The interrupt pin pulls low only while the flag is set and A3 enabled it
    // at the last timer access.
    assign bus.timer_irq_n = !(irq_en_reg && flag_reg);

    // ****************************************************************
    // Port pins
    // ****************************************************************
    assign pa_out = pa_data_reg;
    assign pa_oe_n = ~port_a_direction_reg;
    assign pb_out = pb_data_reg;
    assign pb_oe_n = ~port_b_direction_reg;
endmodule : rrt_device
`default_nettype wire

// file: hw/rrt_host.sv
// Host end: APB-programmed master that drives selects, address and data.
`timescale 1ns/1ps
`default_nettype none
module rrt_host
    import rrt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    rrt_bus_if.host bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    typedef enum logic [1:0] {RRT_IDLE, RRT_DRIVE, RRT_CAPTURE} rrt_state_t;
    rrt_state_t state_reg;
    logic [31:0] cmd_reg;
    logic [7:0] wdata_reg, rdata_reg;
    logic [1:0] status_reg, mask_reg;
    logic wr_acc, rd_acc, done_evt, pin_irq;
    logic pin_irq_reg;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign done_evt = (state_reg == RRT_CAPTURE);
    assign pin_irq = !bus.timer_irq_n;
    assign irq = |(status_reg & mask_reg);

    // ****************************************************************
    // APB registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata_reg <= 8'h00;
            mask_reg <= 2'h0;
        end else if (wr_acc) begin
            if (paddr[4:0] == RRT_HOST_WDATA) wdata_reg <= pwdata[7:0];
            if (paddr[4:0] == RRT_HOST_MASK) mask_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_irq_reg <= 1'b0;
            status_reg <= 2'h0;
        end else begin
            pin_irq_reg <= pin_irq;
            if (rd_acc && paddr[4:0] == RRT_HOST_STATUS) status_reg <= 2'h0;
            if (done_evt) status_reg[RRT_ST_DONE_BIT] <= 1'b1;
            if (pin_irq && !pin_irq_reg) status_reg[RRT_ST_IRQ_BIT] <= 1'b1;
        end
    end

    always_comb begin
        unique case (paddr[4:0])
            RRT_HOST_CMD: prdata = cmd_reg;
            RRT_HOST_WDATA: prdata = {24'h000000, wdata_reg};
            RRT_HOST_RDATA: prdata = {24'h000000, rdata_reg};
            RRT_HOST_STATUS: prdata = {29'h0, state_reg != RRT_IDLE, status_reg};
            RRT_HOST_MASK: prdata = {30'h0, mask_reg};
            default: prdata = 32'h00000000;
        endcase
    end

    // ****************************************************************
    // Device bus cycle: one cycle driving, one cycle capturing.
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RRT_IDLE;
            cmd_reg <= 32'h00000000;
            rdata_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                RRT_IDLE: if (wr_acc && paddr[4:0] == RRT_HOST_CMD) begin
                    cmd_reg <= pwdata;
                    state_reg <= RRT_DRIVE;
                end
                RRT_DRIVE: state_reg <= RRT_CAPTURE;
                RRT_CAPTURE: begin
                    if (!bus.dev_d_oe_n) rdata_reg <= bus.dev_d;
                    state_reg <= RRT_IDLE;
                end
                default: state_reg <= RRT_IDLE;
            endcase
        end
    end

    // At most one select is raised, so the device decodes at most one target.
    always_comb begin
        bus.rom_sel = (state_reg == RRT_DRIVE) && cmd_reg[13:12] == 2'(RRT_SEL_ROM);
        bus.ram_sel = (state_reg == RRT_DRIVE) && cmd_reg[13:12] == 2'(RRT_SEL_RAM);
        bus.iot_sel = (state_reg == RRT_DRIVE) && cmd_reg[13:12] == 2'(RRT_SEL_IOT);
        bus.rw = cmd_reg[RRT_CMD_RW_BIT];
        bus.addr = cmd_reg[9:0];
        bus.host_d = wdata_reg;
        bus.host_d_oe_n = !((state_reg == RRT_DRIVE) && !cmd_reg[RRT_CMD_RW_BIT]);
    end
endmodule : rrt_host
`default_nettype wire

// file: verif/rrt_bus_properties.sv
// Concurrent checks on the bus that joins the host and the device.
`timescale 1ns/1ps
`default_nettype none
module rrt_bus_properties
    import rrt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rom_sel,
    input wire logic ram_sel,
    input wire logic iot_sel,
    input wire logic rw,
    input wire logic [9:0] addr,
    input wire logic [7:0] host_d,
    input wire logic host_d_oe_n,
    input wire logic [7:0] dev_d,
    input wire logic dev_d_oe_n,
    input wire logic timer_irq_n
);
    // ****************************************
    // Helper state
    // ****************************************
    logic any_sel;
    logic tacc;
    logic irq_en_reg;
    logic [7:0] dir_a_reg;
    assign any_sel = rom_sel | ram_sel | iot_sel;
    assign tacc = iot_sel & addr[2];
    // Mirrors the interrupt enable that every timer access latches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= 1'b0;
        end else if (tacc) begin
            irq_en_reg <= addr[3];
        end
    end
    // Mirrors the port A direction register as the host writes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_a_reg <= RRT_REG_RESET;
        end else if (iot_sel && !rw && addr[2:0] == RRT_ADDR_PA_DIR) begin
            dir_a_reg <= host_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Assertions
    // ****************************************
    a_idle_float: assert property (!any_sel |=> dev_d_oe_n)
        else $error("data bus driven without a select");
    a_rom_answer: assert property (rom_sel && !ram_sel && !iot_sel && rw |=> !dev_d_oe_n)
        else $error("rom read not answered");
    a_ram_answer: assert property (ram_sel && !rom_sel && !iot_sel && rw |=> !dev_d_oe_n)
        else $error("ram read not answered");
    a_io_answer: assert property (iot_sel && !rom_sel && !ram_sel && rw |=> !dev_d_oe_n)
        else $error("register read not answered");
    a_write_quiet: assert property (any_sel && !rw |=> dev_d_oe_n)
        else $error("device drove bus on a write");
    a_host_drives: assert property (ram_sel && !rw |-> !host_d_oe_n)
        else $error("host not driving write data");
    a_drive_single: assert property (!dev_d_oe_n |-> ##1 dev_d_oe_n)
        else $error("device held the bus too long");
    a_a3_disables: assert property (tacc && !addr[3] |=> timer_irq_n)
        else $error("interrupt pin active after disable");
    a_irq_enabled: assert property (!timer_irq_n |-> irq_en_reg)
        else $error("interrupt pin low while disabled");
    a_irq_release: assert property ($rose(timer_irq_n) |-> $past(tacc))
        else $error("interrupt released without timer access");
    a_dir_readback: assert property (iot_sel && rw && addr[2:0] == RRT_ADDR_PA_DIR
        |=> dev_d == dir_a_reg)
        else $error("port A direction read back wrong");
    a_flag_byte: assert property (iot_sel && rw && addr[RRT_ADDR_TIMER_BIT]
        && addr[RRT_ADDR_FLAGSEL_BIT] |=> dev_d[6:0] == 7'h00)
        else $error("flag read carries stray bits");
    c_rom_read: cover property (rom_sel && rw);
    c_irq_fall: cover property ($fell(timer_irq_n));
    c_flag_read: cover property (tacc && rw && addr[0]);
endmodule : rrt_bus_properties
`default_nettype wire

// file: verif/rom_ram_io_timer_address_decode_test.sv
// Self-checking testbench for the host and device joined by their bus.
`timescale 1ns/1ps
`default_nettype none
module rom_ram_io_timer_address_decode_test;
    import rrt_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [7:0] pa_in, pb_in, pa_out, pa_oe_n, pb_out, pb_oe_n, rom_data, q;
    int mismatches = 0;
    int checked = 0;
    int divs[4] = '{1, 8, 64, 1024};
    rrt_bus_if bus();
    rrt_device i_rrt_device (.pclk(pclk), .presetn(presetn), .bus(bus.device), .pa_in(pa_in),
        .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
        .rom_data(rom_data));
    rrt_host i_rrt_host (.pclk(pclk), .presetn(presetn), .bus(bus.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    rrt_bus_properties i_rrt_bus_properties (.pclk(pclk), .presetn(presetn),
        .rom_sel(bus.rom_sel), .ram_sel(bus.ram_sel), .iot_sel(bus.iot_sel), .rw(bus.rw),
        .addr(bus.addr), .host_d(bus.host_d), .host_d_oe_n(bus.host_d_oe_n), .dev_d(bus.dev_d),
        .dev_d_oe_n(bus.dev_d_oe_n), .timer_irq_n(bus.timer_irq_n));
    assign rom_data = bus.addr[7:0] ^ 8'ha5;
    always #50 pclk = ~pclk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic dev_op(input rrt_sel_t s, input logic rd, input logic [9:0] a,
        input logic [7:0] wd);
        int n;
        n = 0;
        apb(1'b1, 32'(RRT_HOST_WDATA), {24'h0, wd});
        apb(1'b1, 32'(RRT_HOST_CMD), {15'h0, rd, 2'b00, s, 2'b00, a});
        do begin
            apb(1'b0, 32'(RRT_HOST_STATUS), 32'h0);
            n++;
        end while (r[0] !== 1'b1 && n < 50);
        if (n >= 50) check("done", 8'h00, 8'h01);
        apb(1'b0, 32'(RRT_HOST_RDATA), 32'h0);
        q = r[7:0];
    endtask : dev_op
    task automatic finish_test;
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #8000000;
        mismatches++;
        finish_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pa_in = 8'ha5;
        pb_in = 8'h5a;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        check("idle bus", bus.dev_d_oe_n, 8'h01);
        dev_op(RRT_SEL_ROM, 1'b1, 10'h2c3, 8'h00);
        check("rom byte", q, 8'h66);
        dev_op(RRT_SEL_RAM, 1'b0, 10'h005, 8'h3c);
        dev_op(RRT_SEL_RAM, 1'b0, 10'h03f, 8'hc3);
        dev_op(RRT_SEL_RAM, 1'b1, 10'h005, 8'h00);
        check("ram low", q, 8'h3c);
        dev_op(RRT_SEL_RAM, 1'b1, 10'h03f, 8'h00);
        check("ram top", q, 8'hc3);
        dev_op(RRT_SEL_IOT, 1'b0, 10'h001, 8'hf0);
        dev_op(RRT_SEL_IOT, 1'b0, 10'h003, 8'h0f);
        dev_op(RRT_SEL_IOT, 1'b0, 10'h000, 8'h3c);
        dev_op(RRT_SEL_IOT, 1'b0, 10'h002, 8'h96);
        check("pa dir pins", pa_oe_n, 8'h0f);
        check("pa out", pa_out, 8'h3c);
        check("pb out", pb_out, 8'h96);
        check("pb dir pins", pb_oe_n, 8'hf0);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h001, 8'h00);
        check("pa dir", q, 8'hf0);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h003, 8'h00);
        check("pb dir", q, 8'h0f);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h000, 8'h00);
        check("pa data", q, 8'h35);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h002, 8'h00);
        check("pb data", q, 8'h56);
        check("pa kept", pa_out, 8'h3c);
        apb(1'b0, 32'h14, 32'h0);
        check("unmapped", r[7:0], 8'h00);
        check("no error", pslverr, 8'h00);
        for (int d = 0; d < 4; d++) begin
            dev_op(RRT_SEL_IOT, 1'b0, 10'h004 | 10'(d), 8'h20);
            if (d == 3) begin
                dev_op(RRT_SEL_IOT, 1'b1, 10'h006, 8'h00);
                check("count", q, 8'h20);
            end
            repeat (16 * divs[d]) @(posedge pclk);
            dev_op(RRT_SEL_IOT, 1'b1, 10'h005, 8'h00);
            check("flag early", {7'h0, q[RRT_FLAG_BIT]}, 8'h00);
            repeat (17 * divs[d] + 20) @(posedge pclk);
            dev_op(RRT_SEL_IOT, 1'b1, 10'h005, 8'h00);
            check("flag late", {7'h0, q[RRT_FLAG_BIT]}, 8'h01);
        end
        // Count 11 at divide by 1 expires on the very edge that the next read samples.
        dev_op(RRT_SEL_IOT, 1'b0, 10'h004, 8'h0b);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h005, 8'h00);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h005, 8'h00);
        check("flag kept", {7'h0, q[RRT_FLAG_BIT]}, 8'h01);
        apb(1'b1, 32'(RRT_HOST_MASK), 32'h0);
        dev_op(RRT_SEL_IOT, 1'b0, 10'h00c, 8'h20);
        repeat (60) @(posedge pclk);
        check("irq masked", irq, 8'h00);
        check("irq pin", bus.timer_irq_n, 8'h00);
        apb(1'b1, 32'(RRT_HOST_MASK), 32'h2);
        @(posedge pclk);
        check("irq on", irq, 8'h01);
        apb(1'b0, 32'(RRT_HOST_STATUS), 32'h0);
        check("irq status", {7'h0, r[RRT_ST_IRQ_BIT]}, 8'h01);
        @(posedge pclk);
        check("irq cleared", irq, 8'h00);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h005, 8'h00);
        check("flag set", {7'h0, q[RRT_FLAG_BIT]}, 8'h01);
        check("irq pin off", bus.timer_irq_n, 8'h01);
        dev_op(RRT_SEL_IOT, 1'b1, 10'h005, 8'h00);
        check("flag clear", {7'h0, q[RRT_FLAG_BIT]}, 8'h00);
        finish_test();
    end
endmodule : rom_ram_io_timer_address_decode_test
`default_nettype wire
